// ==== bsrb_exec.sv ====
// executor for carry-or, stack, return, rotate, bit-set and short jump opcodes
// ==========================================================================
// Summary of operation
// - carry-or sets carry when bit is one
// - complement form ors inverse, source untouched
// - pop reads stack, decrements, then writes destination
// - pop into stack pointer: popped value wins
// - push increments pointer then writes source byte
// - subroutine exit pops high then low byte
// - interrupt exit restores counter, pointer minus two
// - interrupt exit releases level, restores nothing else
// - one instruction runs before pending interrupt
// - rotate left moves bit seven to zero
// - rotate left through carry, nine-bit ring
// - rotate right moves bit zero to seven
// - rotate right through carry, nine-bit ring
// - bit-set forces carry or direct bit high
// - short jump adds two plus signed displacement
`timescale 1ns/1ns
module bsrb_exec (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic operand_bit,
  input wire logic [7:0] direct_rd_data,
  input wire logic [7:0] ram_rd_data,
  output logic busy,
  output logic done,
  output logic [7:0] ram_addr,
  output logic ram_we,
  output logic [7:0] ram_wr_data,
  output logic [7:0] direct_addr,
  output logic direct_we,
  output logic [7:0] direct_wr_data,
  output logic bit_we,
  output logic [7:0] bit_addr,
  output logic [7:0] acc,
  output logic carry,
  output logic [7:0] stack_pointer,
  output logic [15:0] program_counter,
  output logic level_release,
  output logic hold_one_insn
);
  import bsrb_pkg::*;

  // ==========================================================================
  // state
  bsrb_phase_t phase_ff, nxt_phase;
  logic [7:0] op_ff, nxt_op;
  logic [7:0] arg_ff, nxt_arg;
  logic [7:0] acc_ff, nxt_acc;
  logic carry_ff, nxt_carry;
  logic [7:0] sp_ff, nxt_sp;
  logic [15:0] pc_ff, nxt_pc;
  logic [7:0] pch_ff, nxt_pch;
  logic done_ff, nxt_done;
  logic rel_ff, nxt_rel;
  logic hold_ff, nxt_hold;
  logic [7:0] daddr_ff, nxt_daddr;
  logic dwe_ff, nxt_dwe;
  logic [7:0] dwd_ff, nxt_dwd;
  logic bwe_ff, nxt_bwe;
  logic [7:0] rot_acc;
  logic rot_carry;
  logic [7:0] sp_dec;

  // ==========================================================================
  // rotate datapath
  bsrb_rotator u_rot (
    .acc_in(acc_ff),
    .carry_in(carry_ff),
    .left(opcode == OP_ROT_L || opcode == OP_ROT_LC),
    .through_carry(opcode == OP_ROT_LC || opcode == OP_ROT_RC),
    .acc_out(rot_acc),
    .carry_out(rot_carry)
  );

  assign sp_dec = sp_ff - SP_STEP;

  // direct address at which the stack pointer is mapped; declared before the decode reads it
  localparam logic [7:0] sp_addr_q = 8'h81;

  // ==========================================================================
  // ram port: combinational so a read lands in the same cycle as its address
  always_comb begin
    ram_addr = sp_ff;
    ram_we = 1'b0;
    ram_wr_data = ZERO8;
    if (phase_ff == BSRB_SECOND && op_ff == OP_PUSH) begin
      ram_addr = sp_ff; // already raised in the first cycle
      ram_we = 1'b1;
      ram_wr_data = direct_rd_data;
    end else if (phase_ff == BSRB_THIRD) begin
      ram_addr = sp_ff; // low byte at the lowered pointer
    end
  end

  // ==========================================================================
  // next-state logic; a 1-cycle opcode completes in the start cycle
  always_comb begin
    nxt_phase = phase_ff;
    nxt_op = op_ff;
    nxt_arg = arg_ff;
    nxt_acc = acc_ff;
    nxt_carry = carry_ff;
    nxt_sp = sp_ff;
    nxt_pc = pc_ff;
    nxt_pch = pch_ff;
    nxt_done = 1'b0;
    nxt_rel = 1'b0;
    nxt_hold = 1'b0;
    nxt_daddr = daddr_ff;
    nxt_dwe = 1'b0;
    nxt_dwd = dwd_ff;
    nxt_bwe = 1'b0;
    case (phase_ff)
      BSRB_IDLE: begin
        if (start) begin
          nxt_op = opcode;
          nxt_arg = operand;
          case (opcode)
            OP_OR_BIT: begin
              nxt_carry = carry_ff | operand_bit;
              nxt_pc = pc_ff + PC_STEP2;
              nxt_phase = BSRB_SECOND;
            end
            OP_OR_NBIT: begin
              nxt_carry = carry_ff | ~operand_bit; // no write-back of source
              nxt_pc = pc_ff + PC_STEP2;
              nxt_phase = BSRB_SECOND;
            end
            OP_POP: begin
              nxt_dwd = ram_rd_data; // read at old pointer
              nxt_sp = sp_dec;
              nxt_daddr = operand;
              nxt_pc = pc_ff + PC_STEP2;
              nxt_phase = BSRB_SECOND;
            end
            OP_PUSH: begin
              nxt_sp = sp_ff + SP_STEP;
              nxt_pc = pc_ff + PC_STEP2;
              nxt_phase = BSRB_SECOND;
            end
            OP_SUB_EXIT, OP_INT_EXIT: begin
              nxt_pch = ram_rd_data; // high byte first
              nxt_sp = sp_dec;
              nxt_phase = BSRB_THIRD;
            end
            OP_ROT_L, OP_ROT_LC, OP_ROT_R, OP_ROT_RC: begin
              nxt_acc = rot_acc;
              nxt_carry = rot_carry;
              nxt_pc = pc_ff + PC_STEP1;
              nxt_done = 1'b1;
            end
            OP_SET_C: begin
              nxt_carry = 1'b1;
              nxt_pc = pc_ff + PC_STEP1;
              nxt_done = 1'b1;
            end
            OP_SET_BIT: begin
              nxt_bwe = 1'b1;
              nxt_daddr = operand;
              nxt_pc = pc_ff + PC_STEP2;
              nxt_done = 1'b1;
            end
            OP_SHORT_RELATIVE_JUMP: begin
              // plus two, then the signed displacement
              nxt_pc = pc_ff + PC_STEP2 + {{8{operand[MSB]}}, operand};
              nxt_phase = BSRB_SECOND;
            end
            default: begin
              nxt_done = 1'b1; // not in this group: report done, change nothing
            end
          endcase
        end
      end
      BSRB_SECOND: begin
        nxt_phase = BSRB_IDLE;
        nxt_done = 1'b1;
        if (op_ff == OP_POP) begin
          nxt_dwe = 1'b1;
          // popped byte overrides the decrement
          if (daddr_ff == sp_addr_q) begin
            nxt_sp = dwd_ff;
          end
        end
      end
      BSRB_THIRD: begin
        nxt_pc = {pch_ff, ram_rd_data};
        nxt_sp = sp_dec; // two lower in total
        nxt_phase = BSRB_IDLE;
        nxt_done = 1'b1;
        if (op_ff == OP_INT_EXIT) begin
          nxt_rel = 1'b1; // only the level is released
          nxt_hold = 1'b1;
        end
      end
      default: begin
        nxt_phase = BSRB_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // registers; clk_en low freezes everything except the synchronous reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_ff <= BSRB_IDLE;
      op_ff <= ZERO8;
      arg_ff <= ZERO8;
      acc_ff <= ACC_RESET;
      carry_ff <= 1'b0;
      sp_ff <= SP_RESET;
      pc_ff <= PC_RESET;
      pch_ff <= ZERO8;
      done_ff <= 1'b0;
      rel_ff <= 1'b0;
      hold_ff <= 1'b0;
      daddr_ff <= ZERO8;
      dwe_ff <= 1'b0;
      dwd_ff <= ZERO8;
      bwe_ff <= 1'b0;
    end else if (clk_en) begin
      phase_ff <= nxt_phase;
      op_ff <= nxt_op;
      arg_ff <= nxt_arg;
      acc_ff <= nxt_acc;
      carry_ff <= nxt_carry;
      sp_ff <= nxt_sp;
      pc_ff <= nxt_pc;
      pch_ff <= nxt_pch;
      done_ff <= nxt_done;
      rel_ff <= nxt_rel;
      hold_ff <= nxt_hold;
      daddr_ff <= nxt_daddr;
      dwe_ff <= nxt_dwe;
      dwd_ff <= nxt_dwd;
      bwe_ff <= nxt_bwe;
    end
  end

  // ==========================================================================
  // outputs
  assign busy = (phase_ff != BSRB_IDLE);
  assign done = done_ff;
  assign direct_addr = daddr_ff;
  assign direct_we = dwe_ff;
  assign direct_wr_data = dwd_ff;
  assign bit_we = bwe_ff;
  assign bit_addr = daddr_ff;
  assign acc = acc_ff;
  assign carry = carry_ff;
  assign stack_pointer = sp_ff;
  assign program_counter = pc_ff;
  assign level_release = rel_ff;
  assign hold_one_insn = hold_ff; // controller must run one more instruction
endmodule : bsrb_exec

// ==== bsrb_exec_monitor.sv ====
// concurrent checks on the executor ports
`timescale 1ns/1ns
module bsrb_exec_monitor
  import bsrb_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic operand_bit,
  input wire logic [7:0] direct_rd_data,
  input wire logic [7:0] ram_addr,
  input wire logic ram_we,
  input wire logic [7:0] ram_wr_data,
  input wire logic direct_we,
  input wire logic [7:0] direct_wr_data,
  input wire logic bit_we,
  input wire logic [7:0] bit_addr,
  input wire logic [7:0] acc,
  input wire logic carry,
  input wire logic [7:0] stack_pointer,
  input wire logic [15:0] program_counter,
  input wire logic level_release,
  input wire logic hold_one_insn
);
  // ====
  // checks assume clk_en held high
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic go;
  assign go = start && !busy;
  rot_left_a: assert property (go && opcode == OP_ROT_L |=> done &&
    acc == {$past(acc[6:0]), $past(acc[7])} && carry == $past(carry)) else $error("rl off");
  rot_left_carry_a: assert property (go && opcode == OP_ROT_LC |=>
    acc == {$past(acc[6:0]), $past(carry)} && carry == $past(acc[7])) else $error("rlc off");
  rot_right_a: assert property (go && opcode == OP_ROT_R |=>
    acc == {$past(acc[0]), $past(acc[7:1])} && carry == $past(carry)) else $error("rr off");
  rot_right_carry_a: assert property (go && opcode == OP_ROT_RC |=>
    acc == {$past(carry), $past(acc[7:1])} && carry == $past(acc[0])) else $error("rrc off");
  carry_or_a: assert property (go && (opcode == OP_OR_BIT || opcode == OP_OR_NBIT)
    |=> !done ##1 done && carry == ($past(carry, 2) |
    ($past(operand_bit, 2) ^ ($past(opcode, 2) == OP_OR_NBIT)))) else $error("or off");
  push_order_a: assert property (go && opcode == OP_PUSH |=> ram_we &&
    ram_addr == $past(stack_pointer) + 8'h01 && ram_wr_data == direct_rd_data ##1 done)
    else $error("push off");
  pop_order_a: assert property (go && opcode == OP_POP && operand != 8'h81 |=> ##1
    done && direct_we && stack_pointer == $past(stack_pointer, 2) - 8'h01) else $error("pop off");
  pop_pointer_a: assert property (go && opcode == OP_POP && operand == 8'h81 |=> ##1
    direct_we && stack_pointer == direct_wr_data) else $error("pop sp off");
  stack_exit_a: assert property (go && (opcode == OP_SUB_EXIT || opcode == OP_INT_EXIT) |=>
    ##1 done && stack_pointer == $past(stack_pointer, 2) - 8'h02) else $error("exit off");
  level_free_a: assert property (go && opcode == OP_INT_EXIT |=>
    !level_release ##1 level_release && hold_one_insn) else $error("release off");
  set_bit_a: assert property (go && opcode == OP_SET_BIT |=> done && bit_we &&
    bit_addr == $past(operand) && carry == $past(carry)) else $error("bit_set_op off");
  short_jump_a: assert property (go && opcode == OP_SHORT_RELATIVE_JUMP |=> ##1 done &&
    program_counter == $past(program_counter, 2) + 16'h0002 +
    {{8{$past(operand[7], 2)}}, $past(operand, 2)}) else $error("jump off");
endmodule : bsrb_exec_monitor
bind bsrb_exec bsrb_exec_monitor bsrb_exec_monitor_i (.clk(clk), .reset_n(reset_n),
  .start(start), .busy(busy), .done(done), .opcode(opcode), .operand(operand),
  .operand_bit(operand_bit), .direct_rd_data(direct_rd_data), .ram_addr(ram_addr),
  .ram_we(ram_we), .ram_wr_data(ram_wr_data), .direct_we(direct_we),
  .direct_wr_data(direct_wr_data), .bit_we(bit_we), .bit_addr(bit_addr), .acc(acc),
  .carry(carry), .stack_pointer(stack_pointer), .program_counter(program_counter),
  .level_release(level_release), .hold_one_insn(hold_one_insn));

// ==== bsrb_pkg.sv ====
// constants and types shared by the bit, stack, rotate and branch executor
package bsrb_pkg;
  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_OR_BIT = 8'h72;
  localparam logic [7:0] OP_OR_NBIT = 8'hA0;
  localparam logic [7:0] OP_POP = 8'hD0;
  localparam logic [7:0] OP_PUSH = 8'hC0;
  localparam logic [7:0] OP_SUB_EXIT = 8'h22;
  localparam logic [7:0] OP_INT_EXIT = 8'h32;
  localparam logic [7:0] OP_ROT_L = 8'h23;
  localparam logic [7:0] OP_ROT_LC = 8'h33;
  localparam logic [7:0] OP_ROT_R = 8'h03;
  localparam logic [7:0] OP_ROT_RC = 8'h13;
  localparam logic [7:0] OP_SET_C = 8'hD3;
  localparam logic [7:0] OP_SET_BIT = 8'hD2;
  localparam logic [7:0] OP_SHORT_RELATIVE_JUMP = 8'h80;
  // ==========================================================================
  // widths, reset values and step sizes
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [15:0] PC_STEP1 = 16'h0001;
  localparam logic [15:0] PC_STEP2 = 16'h0002;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam int MSB = 7;
  // ==========================================================================
  // execution phases, gray coded along idle -> second -> third
  typedef enum logic [1:0] {
    BSRB_IDLE = 2'b00,
    BSRB_SECOND = 2'b01,
    BSRB_THIRD = 2'b11
  } bsrb_phase_t;
endpackage : bsrb_pkg

// ==== bsrb_ram_model.sv ====
// internal data ram model holding the stack
`timescale 1ns/1ns
module bsrb_ram_model (
  input wire logic clk,
  input wire logic [7:0] ram_addr,
  input wire logic ram_we,
  input wire logic [7:0] ram_wr_data,
  output logic [7:0] ram_rd_data
);
  // ====
  // storage, preloaded by the bench
  logic [7:0] mem [256];
  // read is combinational, write lands on the edge
  assign ram_rd_data = mem[ram_addr];
  always @(posedge clk) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wr_data;
    end
  end
endmodule : bsrb_ram_model

// ==== bsrb_rotator.sv ====
// accumulator rotate unit for the four rotate opcodes
`timescale 1ns/1ns
module bsrb_rotator (
  input wire logic [7:0] acc_in,
  input wire logic carry_in,
  input wire logic left,
  input wire logic through_carry,
  output logic [7:0] acc_out,
  output logic carry_out
);
  import bsrb_pkg::*;
  // ==========================================================================
  // ring of 8 or 9 bits chosen by through_carry
  always_comb begin
    if (left) begin
      acc_out = {acc_in[MSB-1:0], through_carry ? carry_in : acc_in[MSB]};
      carry_out = through_carry ? acc_in[MSB] : carry_in;
    end else begin
      acc_out = {through_carry ? carry_in : acc_in[0], acc_in[MSB:1]};
      carry_out = through_carry ? acc_in[0] : carry_in;
    end
  end
endmodule : bsrb_rotator

// ==== bsrb_testbench.sv ====
// self-checking bench for the executor
`timescale 1ns/1ns
module testbench;
  import bsrb_pkg::*;
  // ====
  // signals and reference state
  logic clk, reset_n, start, operand_bit, busy, done, ram_we, direct_we, bit_we, carry, lvl;
  logic [7:0] opcode, operand, dr_data, rd_data, ram_addr, wr_data, acc, sp, dw_data, b_addr;
  logic [15:0] pc, e_pc;
  logic hold;
  logic [7:0] d_addr;
  logic [7:0] e_acc, e_sp, e_mem [256];
  logic e_c;
  logic [31:0] r;
  logic [7:0] ops [13] = '{OP_OR_BIT, OP_OR_NBIT, OP_POP, OP_PUSH, OP_SUB_EXIT, OP_INT_EXIT,
    OP_ROT_L, OP_ROT_LC, OP_ROT_R, OP_ROT_RC, OP_SET_C, OP_SET_BIT, OP_SHORT_RELATIVE_JUMP};
  logic [15:0] corner [18] = '{{OP_SET_C, 8'h00}, {OP_ROT_LC, 8'h00}, {OP_ROT_L, 8'h00},
    {OP_ROT_R, 8'h00}, {OP_ROT_RC, 8'h00}, {OP_OR_NBIT, 8'h00}, {OP_OR_BIT, 8'h01},
    {OP_PUSH, 8'h23}, {OP_PUSH, 8'h01}, {OP_INT_EXIT, 8'h00}, {OP_PUSH, 8'h45},
    {OP_PUSH, 8'h67}, {OP_SUB_EXIT, 8'h00}, {OP_SHORT_RELATIVE_JUMP, 8'h80}, {OP_SHORT_RELATIVE_JUMP, 8'h7F},
    {OP_SHORT_RELATIVE_JUMP, 8'hFE}, {OP_POP, 8'h81}, {OP_SET_BIT, 8'h35}};
  int n_errors = 0, samples_checked = 0, seed = 31, k;
  bsrb_exec bsrb_exec_i (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .start(start),
    .opcode(opcode), .operand(operand), .operand_bit(operand_bit), .direct_rd_data(dr_data),
    .ram_rd_data(rd_data), .busy(busy), .done(done), .ram_addr(ram_addr), .ram_we(ram_we),
    .ram_wr_data(wr_data), .direct_addr(d_addr), .direct_we(direct_we), .direct_wr_data(dw_data),
    .bit_we(bit_we), .bit_addr(b_addr), .acc(acc), .carry(carry), .stack_pointer(sp),
    .program_counter(pc), .level_release(lvl), .hold_one_insn(hold));
  bsrb_ram_model bsrb_ram_model_i (.clk(clk), .ram_addr(ram_addr), .ram_we(ram_we),
    .ram_wr_data(wr_data), .ram_rd_data(rd_data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ====
  // helpers: reference rotate, compare, verdict
  function automatic logic [8:0] rot(logic [7:0] op, logic [7:0] a, logic c);
    case (op)
      OP_ROT_L: return {c, a[6:0], a[7]};
      OP_ROT_LC: return {a[7], a[6:0], c};
      OP_ROT_R: return {c, a[0], a[7:1]};
      default: return {a[0], c, a[7:1]};
    endcase
  endfunction : rot
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // one instruction: predict, issue, wait for done, compare
  task automatic run(logic [7:0] op, logic [7:0] opd, logic ob, logic [7:0] dr);
    logic [7:0] w;
    w = e_mem[e_sp];
    case (op)
      OP_ROT_L, OP_ROT_LC, OP_ROT_R, OP_ROT_RC: {e_c, e_acc} = rot(op, e_acc, e_c);
      OP_SET_C: e_c = 1'b1;
      OP_OR_BIT: e_c = e_c | ob;
      OP_OR_NBIT: e_c = e_c | !ob;
      OP_POP: e_sp = (opd == 8'h81) ? w : e_sp - 8'h01;
      OP_PUSH: e_sp = e_sp + 8'h01;
      OP_SUB_EXIT, OP_INT_EXIT: e_sp = e_sp - 8'h02;
      default: e_c = e_c;
    endcase
    if (op == OP_PUSH) e_mem[e_sp] = dr;
    if (op == OP_SUB_EXIT || op == OP_INT_EXIT) e_pc = {w, e_mem[e_sp + 8'h01]};
    else if (op == OP_SHORT_RELATIVE_JUMP) e_pc = e_pc + 16'h0002 + {{8{opd[7]}}, opd};
    else if (op == 8'hA5) e_pc = e_pc; // opcode outside this group leaves the counter alone
    else e_pc = e_pc + ((op[3:0] == 4'h3) ? 16'h0001 : 16'h0002);
    @(posedge clk);
    start <= 1'b1;
    opcode <= op;
    operand <= opd;
    operand_bit <= ob;
    dr_data <= dr;
    @(posedge clk);
    start <= 1'b0;
    #1;
    for (k = 0; k < 8 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 8) begin
      n_errors++;
      close_out();
    end
    check(acc, e_acc);
    check(carry, e_c);
    check(sp, e_sp);
    check(pc, e_pc);
    check(lvl, op == OP_INT_EXIT);
    check(hold, op == OP_INT_EXIT);
    if (op == OP_POP) check({direct_we, dw_data}, {1'b1, w});
    if (op == OP_POP) check(d_addr, opd);
    if (op == OP_PUSH) check(bsrb_ram_model_i.mem[e_sp], dr);
    if (op == OP_SET_BIT) check({bit_we, b_addr}, {1'b1, opd});
  endtask : run
  // ====
  // main sequence
  initial begin
    reset_n = 1'b0;
    start = 1'b0;
    opcode = 8'h00;
    operand = 8'h00;
    operand_bit = 1'b0;
    dr_data = 8'h00;
    for (k = 0; k < 256; k++) begin
      e_mem[k] = 8'($random(seed));
      bsrb_ram_model_i.mem[k] = e_mem[k];
    end
    {e_acc, e_c, e_sp, e_pc} = {ACC_RESET, 1'b0, SP_RESET, PC_RESET};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 18; i++) run(corner[i][15:8], corner[i][7:0], 1'b0, corner[i][7:0]);
    run(8'hA5, 8'h00, 1'b0, 8'h00); // unknown opcode: done only
    $display("corner cases finished");
    repeat (400) begin
      r = $random(seed);
      run(ops[r[11:8] % 4'hD], r[7:0], r[16], r[31:24]);
    end
    $display("random sequence finished");
    close_out();
  end
endmodule : testbench
